// file: core/sild8_driver.sv
// Eight-stage serial-in latched driver, sampled in the system clock domain
`timescale 1ns/1ps
module sild8_driver #(
    parameter int unsigned N = sild8_pkg::STAGES
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire sild8_pkg::sild8_pins_t pins,
    output logic                  serial_out,
    output logic [N-1:0]          sink_on
);
    // Two-stage synchronisers; first stage feeds only the second
    sild8_pkg::sild8_pins_t meta;
    sild8_pkg::sild8_pins_t sync;
    logic                   sclk_prev;
    logic [N-1:0]           shift;
    logic [N-1:0]           latch;
    logic                   sclk_rise;

    // Shift edges seen since reset, saturating at the stage count
    localparam int unsigned FILL_W = $clog2(N + 1);
    logic [FILL_W-1:0]      stage_fill;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= pins;
            sync <= meta;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sync.shift_clk;
        end
    end

    // Edge detect on the synced level; the previous value resets to the idle low
    // level of the pin, so no false edge appears when reset is released
    assign sclk_rise = sync.shift_clk & ~sclk_prev;

    // stage fill count
    // Only used by the checks below; it proves a bit needs eight edges to reach the end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_fill <= '0;
        end else if (sclk_rise && (stage_fill < FILL_W'(N))) begin
            stage_fill <= FILL_W'(stage_fill + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift <= N'(sild8_pkg::SHIFT_RST);
        end else if (sclk_rise) begin
            shift <= {shift[N-2:0], sync.serial_in};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
        end else if (sclk_rise) begin
            serial_out <= shift[N-2];
        end
    end

    // transparent latches
    // Latch follows the shift value seen this cycle; one cycle behind a shift
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch <= N'(sild8_pkg::LATCH_RST);
        end else if (sync.latch_load) begin
            latch <= shift;
        end
    end

    // output gating
    // Registered so the drivers never glitch while the latch and gate change together
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sink_on <= '0;
        end else if (sync.out_disable) begin
            sink_on <= '0;
        end else begin
            sink_on <= latch;
        end
    end

    AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise |=> shift[0] == $past(sync.serial_in))
        else $error("first stage missed serial data");

    AST_SHIFT_MOVE: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise |=> shift[N-1:1] == $past(shift[N-2:0]))
        else $error("stages did not advance");

    AST_SOUT_LAST: assert property (@(posedge clk) disable iff (!rstn)
        serial_out == shift[N-1])
        else $error("serial out not last stage");

    AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !sclk_rise |=> $stable(shift))
        else $error("shift changed without clock edge");

    AST_LATCH_LOAD: assert property (@(posedge clk) disable iff (!rstn)
        sync.latch_load |=> latch == $past(shift))
        else $error("latch did not copy stages");

    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !sync.latch_load |=> $stable(latch))
        else $error("latch changed while closed");

    AST_DISABLE_OFF: assert property (@(posedge clk) disable iff (!rstn)
        sync.out_disable |=> sink_on == '0)
        else $error("driver on while disabled");

    AST_ENABLE_SHOW: assert property (@(posedge clk) disable iff (!rstn)
        !sync.out_disable |=> sink_on == $past(latch))
        else $error("driver does not show latch");

    AST_DISABLE_KEEP: assert property (@(posedge clk) disable iff (!rstn)
        sync.out_disable && !sync.latch_load |=> $stable(latch))
        else $error("disable disturbed latches");

    AST_SYNC_TRACK: assert property (@(posedge clk) disable iff (!rstn)
        sync == $past(meta))
        else $error("second sync stage lost a sample");

    AST_RISE_SINGLE: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise |=> !sclk_rise)
        else $error("one clock edge counted twice");

    AST_RISE_SOURCE: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise |-> !$past(sync.shift_clk))
        else $error("edge seen without a low level before");

    AST_RISE_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
        !sync.shift_clk |-> !sclk_rise)
        else $error("edge seen while shift clock low");

    AST_SOUT_STEP: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise |=> serial_out == $past(shift[N-2]))
        else $error("serial out did not take next stage");

    AST_SOUT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !sclk_rise |=> $stable(serial_out))
        else $error("serial out moved without clock edge");

    // Reset leaves zeros in every stage, so the end stays low until eight edges pass
    AST_SOUT_EMPTY: assert property (@(posedge clk) disable iff (!rstn)
        (stage_fill < FILL_W'(N)) |-> !serial_out)
        else $error("bit reached serial out too early");

    AST_LATCH_SOURCE: assert property (@(posedge clk) disable iff (!rstn)
        $changed(latch) |-> $past(sync.latch_load))
        else $error("latch changed without strobe");

    AST_LOAD_SHIFT_KEEP: assert property (@(posedge clk) disable iff (!rstn)
        sync.latch_load && !sclk_rise |=> $stable(shift))
        else $error("strobe disturbed shift stages");

    AST_DISABLE_SHIFT_KEEP: assert property (@(posedge clk) disable iff (!rstn)
        sync.out_disable && !sclk_rise |=> $stable(shift))
        else $error("disable disturbed shift stages");

    AST_SINK_STEADY: assert property (@(posedge clk) disable iff (!rstn)
        !sync.out_disable ##1 (!sync.out_disable && $stable(latch)) |=> $stable(sink_on))
        else $error("driver moved with steady latch");

    AST_SINK_SUBSET: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> (sink_on & ~$past(latch)) == '0)
        else $error("driver on for a latched zero");

    AST_SINK_ANY_ON: assert property (@(posedge clk) disable iff (!rstn)
        !sync.out_disable && (latch != '0) |=> sink_on != '0)
        else $error("latched one left driver off");
endmodule

// file: core/sild8_pkg.sv
// Package: widths, timing constants and carrier types for the latched driver
package sild8_pkg;
    localparam int unsigned STAGES         = 8;
    localparam int unsigned CLK_PERIOD_NS  = 50;
    // Far-side minimum timings, kept for documentation only; no check or model uses them
    localparam int unsigned SCLK_MIN_NS    = 150;
    localparam int unsigned STB_MIN_NS     = 100;
    localparam int unsigned CLK2STB_MIN_NS = 30;
    localparam int unsigned SCLK_MIN_CYC   = (SCLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STB_MIN_CYC    = (STB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CLK2STB_CYC    = (CLK2STB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  SHIFT_RST      = 8'h00;
    localparam logic [7:0]  LATCH_RST      = 8'h00;

    // Pin group driven by the controller
    typedef struct packed {
        logic serial_in;
        logic shift_clk;
        logic latch_load;
        logic out_disable;
    } sild8_pins_t;
endpackage

// file: tb/sild8_ctrl.sv
// Controller model driving the serial, clock, strobe and disable pins
`timescale 1ns/1ps
module sild8_ctrl (
    input  wire logic          clk,
    output sild8_pkg::sild8_pins_t pins
);
    initial pins = '0;
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic put_byte(input logic [7:0] d);
        @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            pins.serial_in <= d[i];
            hold(3);
            pins.shift_clk <= 1'b1;
            hold(4);
            pins.shift_clk <= 1'b0;
            hold(4);
        end
        // Hold time over: line no longer shows the last bit
        pins.serial_in <= ~d[0];
    endtask
    task automatic set_lines(input logic ld, input logic dis);
        @(posedge clk);
        pins.latch_load <= ld;
        pins.out_disable <= dis;
        hold(5);
    endtask
    task automatic strobe();
        hold(1);
        set_lines(1'b1, pins.out_disable);
        set_lines(1'b0, pins.out_disable);
    endtask
endmodule

// file: tb/serial_in_latched_driver8_bench.sv
// Self-checking bench for the latched serial driver
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module serial_in_latched_driver8_bench;
    logic                   clk = 1'b0;
    logic                   rstn = 1'b0;
    sild8_pkg::sild8_pins_t pins;
    logic                   serial_out;
    logic [7:0]             sink_on;
    int                     errors = 0;
    int                     checks = 0;
    int                     cycles = 0;
    always #25 clk = ~clk;
    sild8_ctrl u_ctrl (.clk(clk), .pins(pins));
    sild8_driver u_dut (.clk(clk), .rstn(rstn), .pins(pins),
        .serial_out(serial_out), .sink_on(sink_on));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_load();
        @(negedge clk);
        `CHK(sink_on, 8'h00)
        u_ctrl.put_byte(8'ha5);
        @(negedge clk);
        `CHK(serial_out, 1'b1)
        `CHK(sink_on, 8'h00)
        u_ctrl.strobe();
        @(negedge clk);
        `CHK(sink_on, 8'ha5)
        $display("done load");
    endtask
    task automatic t_cascade();
        u_ctrl.put_byte(8'h3c);
        @(negedge clk);
        `CHK(serial_out, 1'b0)
        `CHK(sink_on, 8'ha5)
        $display("done cascade");
    endtask
    task automatic t_disable();
        u_ctrl.set_lines(1'b0, 1'b1);
        @(negedge clk);
        `CHK(sink_on, 8'h00)
        u_ctrl.strobe();
        @(negedge clk);
        `CHK(sink_on, 8'h00)
        u_ctrl.set_lines(1'b0, 1'b0);
        @(negedge clk);
        `CHK(sink_on, 8'h3c)
        $display("done disable");
    endtask
    task automatic t_bypass();
        u_ctrl.set_lines(1'b1, 1'b1);
        u_ctrl.put_byte(8'h81);
        @(negedge clk);
        `CHK(sink_on, 8'h00)
        u_ctrl.set_lines(1'b1, 1'b0);
        @(negedge clk);
        `CHK(sink_on, 8'h81)
        u_ctrl.set_lines(1'b0, 1'b0);
        $display("done bypass");
    endtask
    // Ceiling of 3000 cycles, well above the four tests of about 330 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_load();
        t_cascade();
        t_disable();
        t_bypass();
        stop_test();
    end
endmodule
